// *** rtl/ic_pkg.sv ***
// Shared constants and carrier types for the instruction cache.
// Assumes a 32-bit virtual fetch address and 32-bit memory words.
package ic_pkg;

  // Geometry
  localparam int ADDR_W     = 32;
  localparam int WORD_W     = 32;
  localparam int LINE_WORDS = 8;
  localparam int WAYS       = 32;
  localparam int LINES      = 512;
  localparam int SETS       = LINES / WAYS;
  localparam int WORD_LSB   = 2;
  localparam int SET_LSB    = 5;
  localparam int TAG_LSB    = 9;
  localparam int TAG_W      = ADDR_W - TAG_LSB;

  // Control-register fields and reset values
  localparam int         CTRL_MMU_BIT = 0;
  localparam int         CTRL_IC_BIT  = 12;
  localparam logic       CTRL_RST_VAL = 1'b0;

  // Cache-operations encodings that invalidate the instruction side
  localparam logic [2:0] COP_OPC2_FLUSH = 3'h0;
  localparam logic [3:0] COP_CRM_I      = 4'h5;
  localparam logic [3:0] COP_CRM_ID     = 4'h7;

  // Fill counter and round-robin pointer values
  localparam logic [2:0] BEAT_FIRST = 3'h0;
  localparam logic [2:0] BEAT_LAST  = 3'h7;
  localparam logic [4:0] RR_RST_VAL = 5'h00;

  typedef enum logic [1:0] {
    IC_IDLE   = 2'b00,
    IC_LOOK   = 2'b01,
    IC_FILL   = 2'b10,
    IC_SINGLE = 2'b11
  } ic_state_t;

  // Fetch request from the core
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cacheable;
  } ic_fetch_t;

  // Read command to memory
  typedef struct packed {
    logic              req;
    logic              line;
    logic [ADDR_W-1:0] addr;
  } ic_mem_cmd_t;

  // Write into a coprocessor register
  typedef struct packed {
    logic              ctrl_wr;
    logic              cop_wr;
    logic [2:0]        opc2;
    logic [3:0]        crm;
    logic [WORD_W-1:0] wdata;
  } ic_cfg_wr_t;

endpackage : ic_pkg

// *** rtl/ic_cache.sv ***
// Virtually addressed 32-way instruction cache with line refill.
// Assumes one fetch outstanding, memory answering with mem_rvalid beats,
// and control/cache-op writes arriving as one-cycle strobes.
//
// Contract
// - 16 KB, 512 lines of 32 bytes, 32-way.
// - Index and tag with virtual fetch address.
// - Refill always whole eight-word lines.
// - Translation off means every address cacheable.
// - Every fetch looked up; attribute affects misses.
// - Cacheable miss with cache enabled fills line into round-robin way.
// - Uncacheable miss: one word read, no write.
// - No write-buffer snoop; stores never update.
// - Invalidate operation clears all lines at once, except a line whose fill completes that cycle.
// - Hardware reset disables, invalidates; soft resets disable.
// - Enabled cache allocates only cacheable read misses.
// - Disabled cache allocates nothing, still hits.
// - Control bit 12 enables or disables cache.
// - One write enables translation and cache together.
// - Reset clears every writable control bit.
// - Enable field reads zero off, one on.

module ic_cache #(
  parameter int WAYS       = ic_pkg::WAYS,
  parameter int SETS       = ic_pkg::SETS,
  parameter int LINE_WORDS = ic_pkg::LINE_WORDS
) (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire logic                        clk_en,
  input  wire logic                        soft_reset,
  input  wire ic_pkg::ic_cfg_wr_t          cfg_wr,
  input  wire logic                        fetch_req,
  input  wire ic_pkg::ic_fetch_t           fetch,
  output      logic                        fetch_ack_q,
  output      logic [ic_pkg::WORD_W-1:0]   fetch_data_q,
  output      logic                        fetch_hit_q,
  output      logic                        fetch_busy_q,
  output      ic_pkg::ic_mem_cmd_t         mem_cmd_q,
  input  wire logic                        mem_rvalid,
  input  wire logic [ic_pkg::WORD_W-1:0]   mem_rdata,
  output      logic                        icache_en_q,
  output      logic                        mmu_en_q
);

  localparam int WAY_W  = $clog2(WAYS);
  localparam int SET_W  = $clog2(SETS);
  localparam int WORD_I = $clog2(LINE_WORDS);
  localparam int DATA_N = SETS * WAYS * LINE_WORDS;

  ////////////////////////////////////////////////////////////////////////////
  // Storage (no reset on data/tags; a hit needs the valid bit as well as a tag match)
  logic [ic_pkg::WORD_W-1:0] data_q  [DATA_N];
  logic [ic_pkg::TAG_W-1:0]  tag_q   [SETS][WAYS];
  logic [WAYS-1:0]           valid_q [SETS];
  logic [WAY_W-1:0]          rr_q    [SETS];

  ic_pkg::ic_state_t         state_q;
  ic_pkg::ic_state_t         state_d;
  ic_pkg::ic_fetch_t         req_q;
  logic [WORD_I-1:0]         beat_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode from the virtual address as issued by the core
  wire [SET_W-1:0]  req_set  = req_q.addr[ic_pkg::SET_LSB +: SET_W];
  wire [ic_pkg::TAG_W-1:0] req_tag = req_q.addr[ic_pkg::ADDR_W-1:ic_pkg::TAG_LSB];
  wire [WORD_I-1:0] req_word = req_q.addr[ic_pkg::WORD_LSB +: WORD_I];
  wire [WAY_W-1:0]  rr_cur   = rr_q[req_set];

  // Parallel tag compare across all ways of the set
  logic [WAYS-1:0]  way_hit;
  genvar w;
  generate
    for (w = 0; w < WAYS; w++) begin : g_cmp
      assign way_hit[w] = valid_q[req_set][w] && (tag_q[req_set][w] == req_tag);
    end
  endgenerate

  // Encode the hitting way; at most one way matches a tag
  logic [WAY_W-1:0] hit_way;
  always_comb begin
    hit_way = '0;
    for (int i = 0; i < WAYS; i++) begin
      if (way_hit[i]) begin
        hit_way = WAY_W'(i);
      end
    end
  end

  wire              hit       = |way_hit;
  wire [SET_W+WAY_W+WORD_I-1:0] rd_idx = {req_set, hit_way, req_word};
  wire [SET_W+WAY_W+WORD_I-1:0] wr_idx = {req_set, rr_cur, beat_q};
  // Translation off forces cacheable
  wire              cacheable = req_q.cacheable || !mmu_en_q;
  wire              alloc_ok  = icache_en_q && cacheable;
  wire              in_look   = (state_q == ic_pkg::IC_LOOK);
  wire              miss      = in_look && !hit;
  wire              fill_last = (state_q == ic_pkg::IC_FILL) && mem_rvalid &&
                                (beat_q == ic_pkg::BEAT_LAST);
  wire              inval_wr  = cfg_wr.cop_wr &&
                                (cfg_wr.opc2 == ic_pkg::COP_OPC2_FLUSH) &&
                                ((cfg_wr.crm == ic_pkg::COP_CRM_I) ||
                                 (cfg_wr.crm == ic_pkg::COP_CRM_ID));
  wire [WAYS-1:0]   valid_any_v;
  generate
    for (w = 0; w < WAYS; w++) begin : g_any
      logic [SETS-1:0] col;
      for (genvar s = 0; s < SETS; s++) begin : g_set
        assign col[s] = valid_q[s][w];
      end
      assign valid_any_v[w] = |col;
    end
  endgenerate
  wire              valid_any = |valid_any_v;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: lookup, then line fill or single-word read on a miss
  always_comb begin
    state_d = state_q;
    case (state_q)
      ic_pkg::IC_IDLE: begin
        if (fetch_req) begin
          state_d = ic_pkg::IC_LOOK;
        end
      end
      ic_pkg::IC_LOOK: begin
        if (hit) begin
          state_d = ic_pkg::IC_IDLE;
        end else if (alloc_ok) begin
          state_d = ic_pkg::IC_FILL;
        end else begin
          state_d = ic_pkg::IC_SINGLE;
        end
      end
      // Back to lookup so the fresh line serves the fetch as a hit
      ic_pkg::IC_FILL: begin
        if (fill_last) begin
          state_d = ic_pkg::IC_LOOK;
        end
      end
      ic_pkg::IC_SINGLE: begin
        if (mem_rvalid) begin
          state_d = ic_pkg::IC_IDLE;
        end
      end
      default: state_d = ic_pkg::IC_IDLE;
    endcase
  end

  // State and request capture
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ic_pkg::IC_IDLE;
      req_q   <= '0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (state_q == ic_pkg::IC_IDLE && fetch_req) begin
        req_q <= fetch;
      end
    end
  end

  // Beat counter for the eight-word fill
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      beat_q <= ic_pkg::BEAT_FIRST;
    end else if (clk_en) begin
      if (miss) begin
        beat_q <= ic_pkg::BEAT_FIRST;
      end else if (state_q == ic_pkg::IC_FILL && mem_rvalid) begin
        beat_q <= beat_q + WORD_I'(1);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line data written only by fills; stores never reach here
  always_ff @(posedge mclk) begin
    if (clk_en && state_q == ic_pkg::IC_FILL && mem_rvalid) begin
      data_q[wr_idx] <= mem_rdata;
    end
  end

  // Tag written with the last beat of a fill
  always_ff @(posedge mclk) begin
    if (clk_en && fill_last) begin
      tag_q[req_set][rr_cur] <= req_tag;
    end
  end

  // Valid bits: a completing fill beats a same-cycle invalidate
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < SETS; s++) begin
        valid_q[s] <= '0;
      end
    end else if (clk_en) begin
      for (int s = 0; s < SETS; s++) begin
        if (inval_wr) begin
          valid_q[s] <= '0;
        end
      end
      if (fill_last) begin
        valid_q[req_set][rr_cur] <= 1'b1;
      end
    end
  end

  // Round-robin pointer per set; wraps naturally at the way count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < SETS; s++) begin
        rr_q[s] <= ic_pkg::RR_RST_VAL;
      end
    end else if (clk_en && fill_last) begin
      rr_q[req_set] <= rr_cur + WAY_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control bits; one write may turn on translation and cache together
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      icache_en_q <= ic_pkg::CTRL_RST_VAL;
      mmu_en_q    <= ic_pkg::CTRL_RST_VAL;
    end else if (clk_en) begin
      if (soft_reset) begin
        icache_en_q <= ic_pkg::CTRL_RST_VAL;
        mmu_en_q    <= ic_pkg::CTRL_RST_VAL;
      end else if (cfg_wr.ctrl_wr) begin
        icache_en_q <= cfg_wr.wdata[ic_pkg::CTRL_IC_BIT];
        mmu_en_q    <= cfg_wr.wdata[ic_pkg::CTRL_MMU_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core answer and memory command, all registered
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      fetch_ack_q  <= 1'b0;
      fetch_hit_q  <= 1'b0;
      fetch_data_q <= '0;
      fetch_busy_q <= 1'b0;
      mem_cmd_q    <= '0;
    end else if (clk_en) begin
      fetch_ack_q  <= (in_look && hit) ||
                      (state_q == ic_pkg::IC_SINGLE && mem_rvalid);
      fetch_hit_q  <= in_look && hit;
      fetch_busy_q <= (state_d != ic_pkg::IC_IDLE);
      if (in_look && hit) begin
        fetch_data_q <= data_q[rd_idx];
      end else if (state_q == ic_pkg::IC_SINGLE && mem_rvalid) begin
        fetch_data_q <= mem_rdata;
      end
      // Line fills start at the line's first word
      mem_cmd_q.req  <= miss;
      mem_cmd_q.line <= miss && alloc_ok;
      if (miss) begin
        mem_cmd_q.addr <= alloc_ok ?
          {req_q.addr[ic_pkg::ADDR_W-1:ic_pkg::SET_LSB], {ic_pkg::SET_LSB{1'b0}}} :
          {req_q.addr[ic_pkg::ADDR_W-1:ic_pkg::WORD_LSB], {ic_pkg::WORD_LSB{1'b0}}};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_hit_ack;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && in_look && hit) |=> (fetch_ack_q && fetch_hit_q && !mem_cmd_q.req);
  endproperty
  a_hit_ack: assert property (p_hit_ack) else $error("hit not acknowledged");

  property p_fill_cmd;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && miss && icache_en_q && (req_q.cacheable || !mmu_en_q))
        |=> (mem_cmd_q.req && mem_cmd_q.line && state_q == ic_pkg::IC_FILL);
  endproperty
  a_fill_cmd: assert property (p_fill_cmd) else $error("no line fill");

  property p_single_cmd;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && miss && mmu_en_q && !req_q.cacheable)
        |=> (mem_cmd_q.req && !mem_cmd_q.line && state_q == ic_pkg::IC_SINGLE);
  endproperty
  a_single_cmd: assert property (p_single_cmd) else $error("bad single read");

  property p_no_alloc_off;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && miss && !icache_en_q) |=> (state_q == ic_pkg::IC_SINGLE);
  endproperty
  a_no_alloc_off: assert property (p_no_alloc_off) else $error("alloc while off");

  property p_inval;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && inval_wr && !fill_last) |=> !valid_any;
  endproperty
  a_inval: assert property (p_inval) else $error("invalidate left lines");

  property p_ctrl_wr;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && cfg_wr.ctrl_wr && !soft_reset)
        |=> (icache_en_q == $past(cfg_wr.wdata[ic_pkg::CTRL_IC_BIT]) &&
             mmu_en_q == $past(cfg_wr.wdata[ic_pkg::CTRL_MMU_BIT]));
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("control write lost");

  property p_soft_rst;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && soft_reset) |=> !icache_en_q;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset left cache on");

  property p_rr_step;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && fill_last) |=> (rr_cur == $past(rr_cur) + WAY_W'(1) && hit);
  endproperty
  a_rr_step: assert property (p_rr_step) else $error("pointer not advanced");

  property p_fill_end;
    @(posedge mclk) disable iff (!rst_n)
      (clk_en && fill_last) |=> (state_q == ic_pkg::IC_LOOK && beat_q == ic_pkg::BEAT_FIRST);
  endproperty
  a_fill_end: assert property (p_fill_end) else $error("fill length wrong");

  c_hit:    cover property (@(posedge mclk) disable iff (!rst_n) fetch_hit_q);
  c_fill:   cover property (@(posedge mclk) disable iff (!rst_n) fill_last);
  c_single: cover property (@(posedge mclk) disable iff (!rst_n)
                            state_q == ic_pkg::IC_SINGLE && mem_rvalid);
  c_inval:  cover property (@(posedge mclk) disable iff (!rst_n) inval_wr && valid_any);

endmodule : ic_cache

// *** sim/ic_mem_model.sv ***
// Behavioural memory behind the instruction cache.
// Assumes one-cycle command pulses and answers with 8 or 1 beats.
module ic_mem_model (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire ic_pkg::ic_mem_cmd_t   cmd,
  input  wire logic                  slow,
  input  wire logic [7:0]            gen,
  output      logic                  rvalid,
  output      logic [31:0]           rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0]  left_q;
  logic [31:0] addr_q;
  logic        ph_q;

  ////////////////////////////////////////////////////////////////////////////
  // Beats return in word order; slow mode inserts a gap before each beat
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 4'h0;
      addr_q <= 32'h0;
      ph_q   <= 1'b0;
      rvalid <= 1'b0;
      rdata  <= 32'h0;
    end else begin
      ph_q <= ~ph_q;
      if (cmd.req) begin
        left_q <= cmd.line ? 4'h8 : 4'h1;
        addr_q <= cmd.addr;
        rvalid <= 1'b0;
        rdata  <= ~rdata;
      end else if (left_q != 4'h0 && (!slow || ph_q)) begin
        rvalid <= 1'b1;
        rdata  <= addr_q ^ {gen, 24'h0};
        addr_q <= addr_q + 32'h4;
        left_q <= left_q - 4'h1;
      end else begin
        // Idle bus shows the inverse so stale data never matches
        rvalid <= 1'b0;
        rdata  <= ~rdata;
      end
    end
  end
endmodule : ic_mem_model

// *** sim/instruction_cache_tb.sv ***
// Self-checking bench for the instruction cache.
// Assumes the memory model as far side and inputs driven at falling edges.
module instruction_cache_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                mclk;
  logic                rst_n;
  logic                soft_reset;
  logic                clk_en;
  ic_pkg::ic_cfg_wr_t  cfg_wr;
  logic                fetch_req;
  ic_pkg::ic_fetch_t   fetch;
  logic                fetch_ack_q;
  logic [31:0]         fetch_data_q;
  logic                fetch_hit_q;
  logic                fetch_busy_q;
  ic_pkg::ic_mem_cmd_t mem_cmd_q;
  logic                mem_rvalid;
  logic [31:0]         mem_rdata;
  logic                icache_en_q;
  logic                mmu_en_q;
  logic                slow;
  logic [7:0]          gen;
  int                  err_count;
  int                  comparisons;

  ic_cache uut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .soft_reset(soft_reset),
    .cfg_wr(cfg_wr), .fetch_req(fetch_req), .fetch(fetch), .fetch_ack_q(fetch_ack_q),
    .fetch_data_q(fetch_data_q), .fetch_hit_q(fetch_hit_q), .fetch_busy_q(fetch_busy_q),
    .mem_cmd_q(mem_cmd_q), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .icache_en_q(icache_en_q), .mmu_en_q(mmu_en_q));

  ic_mem_model mem (.mclk(mclk), .rst_n(rst_n), .cmd(mem_cmd_q), .slow(slow), .gen(gen),
    .rvalid(mem_rvalid), .rdata(mem_rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Clock at 50 MHz
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [31:0] expw(input logic [31:0] a, input logic [7:0] g);
    return {a[31:2], 2'b00} ^ {g, 24'h0};
  endfunction : expw

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cfg(input logic ctrl, input logic cop, input logic [3:0] crm,
                     input logic [31:0] wd);
    @(negedge mclk);
    cfg_wr = '{ctrl_wr: ctrl, cop_wr: cop, opc2: 3'h0, crm: crm, wdata: wd};
    @(negedge mclk);
    cfg_wr.ctrl_wr = 1'b0;
    cfg_wr.cop_wr  = 1'b0;
  endtask : cfg

  // Kind: 0 served from cache, 1 single-word read, 2 line fill
  task automatic fetch_chk(input logic [31:0] a, input logic c, input logic [1:0] kind,
                           input logic [31:0] exp);
    logic [1:0]  seen;
    logic [31:0] maddr;
    int          n;
    seen  = 2'h0;
    maddr = 32'h0;
    @(negedge mclk);
    fetch_req = 1'b1;
    fetch     = '{addr: a, cacheable: c};
    @(negedge mclk);
    fetch_req = 1'b0;
    // Lookup cycle: the request has been taken
    chk(fetch_busy_q, 1'b1);
    for (n = 0; n < 200 && fetch_ack_q !== 1'b1; n++) begin
      if (mem_cmd_q.req === 1'b1) begin
        seen  = {1'b1, mem_cmd_q.line};
        maddr = mem_cmd_q.addr;
      end
      @(negedge mclk);
    end
    if (n == 200) begin
      chk(32'h0, 32'h1);
      summarize();
    end
    chk(fetch_busy_q, 1'b0);
    chk(seen, {kind != 2'h0, kind == 2'h2});
    chk(fetch_hit_q, kind != 2'h1);
    chk(fetch_data_q, exp);
    if (kind != 2'h0) chk(maddr, kind == 2'h2 ? {a[31:5], 5'h0} : {a[31:2], 2'h0});
  endtask : fetch_chk

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    chk({icache_en_q, mmu_en_q, fetch_ack_q, fetch_busy_q, mem_cmd_q.req}, 32'h0);
  endtask : t_reset

  task automatic t_fill();
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_1001);
    chk({icache_en_q, mmu_en_q}, 32'h3);
    gen = 8'h01;
    fetch_chk(32'h0000_1234, 1'b1, 2'h2, expw(32'h0000_1234, 8'h01));
    fetch_chk(32'h0000_123c, 1'b1, 2'h0, expw(32'h0000_123c, 8'h01));
    gen = 8'h02;
    fetch_chk(32'h0000_1230, 1'b1, 2'h0, expw(32'h0000_1230, 8'h01));
  endtask : t_fill

  task automatic t_uncache();
    fetch_chk(32'h0000_4404, 1'b0, 2'h1, expw(32'h0000_4404, 8'h02));
    fetch_chk(32'h0000_4404, 1'b0, 2'h1, expw(32'h0000_4404, 8'h02));
    fetch_chk(32'h0000_1234, 1'b0, 2'h0, expw(32'h0000_1234, 8'h01));
  endtask : t_uncache

  task automatic t_mmuoff();
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_1000);
    fetch_chk(32'h0000_8808, 1'b0, 2'h2, expw(32'h0000_8808, 8'h02));
    fetch_chk(32'h0000_8800, 1'b0, 2'h0, expw(32'h0000_8800, 8'h02));
  endtask : t_mmuoff

  task automatic t_disable();
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_0001);
    chk(icache_en_q, 1'b0);
    fetch_chk(32'h0000_1234, 1'b1, 2'h0, expw(32'h0000_1234, 8'h01));
    fetch_chk(32'h0000_c010, 1'b1, 2'h1, expw(32'h0000_c010, 8'h02));
    fetch_chk(32'h0000_c010, 1'b1, 2'h1, expw(32'h0000_c010, 8'h02));
  endtask : t_disable

  task automatic t_inval();
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_1001);
    cfg(1'b0, 1'b1, 4'h6, 32'h0);
    fetch_chk(32'h0000_1234, 1'b1, 2'h0, expw(32'h0000_1234, 8'h01));
    cfg(1'b0, 1'b1, 4'h5, 32'h0);
    fetch_chk(32'h0000_1234, 1'b1, 2'h2, expw(32'h0000_1234, 8'h02));
    cfg(1'b0, 1'b1, 4'h7, 32'h0);
    gen = 8'h03;
    fetch_chk(32'h0000_1234, 1'b1, 2'h2, expw(32'h0000_1234, 8'h03));
  endtask : t_inval

  task automatic t_soft();
    @(negedge mclk);
    soft_reset = 1'b1;
    @(negedge mclk);
    soft_reset = 1'b0;
    @(negedge mclk);
    chk({icache_en_q, mmu_en_q}, 32'h0);
    fetch_chk(32'h0000_1234, 1'b1, 2'h0, expw(32'h0000_1234, 8'h03));
  endtask : t_soft

  // 33 fills in one set wrap the pointer back past way zero
  task automatic t_rr();
    int i;
    slow = 1'b1;
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_1001);
    cfg(1'b0, 1'b1, 4'h7, 32'h0);
    for (i = 0; i < 33; i++) begin
      fetch_chk((i << 9) | 32'h64, 1'b1, 2'h2, expw((i << 9) | 32'h64, 8'h03));
    end
    fetch_chk(32'h0000_0264, 1'b1, 2'h0, expw(32'h0000_0264, 8'h03));
    fetch_chk(32'h0000_0064, 1'b1, 2'h2, expw(32'h0000_0064, 8'h03));
    fetch_chk(32'h0000_0264, 1'b1, 2'h2, expw(32'h0000_0264, 8'h03));
  endtask : t_rr

  // Enable low while idle: a control write in that cycle must be lost
  task automatic t_freeze();
    @(negedge mclk);
    clk_en = 1'b0;
    cfg(1'b1, 1'b0, 4'h0, 32'h0);
    chk({icache_en_q, mmu_en_q}, 32'h3);
    chk(fetch_data_q, expw(32'h0000_0264, 8'h03));
    clk_en = 1'b1;
  endtask : t_freeze

  // Mid-run hardware reset: enables drop and every line is gone
  task automatic t_hwreset();
    @(negedge mclk);
    rst_n = 1'b0;
    repeat (2) @(negedge mclk);
    t_reset();
    rst_n = 1'b1;
    cfg(1'b1, 1'b0, 4'h0, 32'h0000_1001);
    fetch_chk(32'h0000_0264, 1'b1, 2'h2, expw(32'h0000_0264, 8'h03));
  endtask : t_hwreset

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    err_count   = 0;
    comparisons = 0;
    rst_n       = 1'b0;
    soft_reset  = 1'b0;
    cfg_wr      = '0;
    fetch_req   = 1'b0;
    fetch       = '0;
    slow        = 1'b0;
    clk_en      = 1'b1;
    gen         = 8'h00;
    repeat (2) @(negedge mclk);
    t_reset();
    rst_n = 1'b1;
    t_fill();
    t_uncache();
    t_mmuoff();
    t_disable();
    t_inval();
    t_soft();
    t_rr();
    t_freeze();
    t_hwreset();
    summarize();
  end
endmodule : instruction_cache_tb
